// *** irfg_gate.sv ***
// IR flash safety gate: strobe limiting, fault supervision and register slave
//
// Contract
// - Cut drive after exposure limit of strobe
// - Enforce frame-rate spacing between propagated pulses
// - Flag open load and cathode shorts
// - Flag long/frequent strobe, resistor, thermal, undervoltage
// - Classify cathode level low/high as shorts
// - Check short to ground only with drive off
// - Open load after 22 us blanking
// - Open load keeps drive active
// - Open load clears on fall or expiry
// - Held strobe pulses after frame timer, exposure-long
// - Resistor fault filtered, drive off, flagged
// - Over-temperature filtered, drive off, flagged
// - Diagnostics only with string supply present
// - Undervoltage holds drive low, flag low
// - Limited strobe turns drive off and flags
// - Early first strobe limited and flagged
// - Short to ground after 10 us blanking
// - Ground short clears on strobe rise
// - Supply short cuts drive, latched until fall/expiry
`timescale 1ns/1ps
`default_nettype none
module irfg_gate #(
   parameter int EXPOSURE_CYCLES = irfg_pkg::EXPOSURE_CYCLES,
   parameter int FRAME_RATE_CYCLES = irfg_pkg::FRAME_RATE_CYCLES
) (
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic [irfg_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [31:0]                  s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [irfg_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [31:0]                       s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready,
   input  wire irfg_pkg::irfg_sense_t        sense,
   output logic                              switch_drive,
   output logic                              fault_flag_n_out,
   output logic                              fault_flag_n_oe
);
   irfg_pkg::irfg_sense_t                     sense_s;
   irfg_pkg::irfg_state_t                     state;
   irfg_pkg::irfg_fault_t                     faults;
   logic [irfg_pkg::FILT_N-1:0]               filt_cond;
   logic [irfg_pkg::FILT_N-1:0]               filt_hit;
   logic [irfg_pkg::LIMIT_W-1:0]              exposure_limit;
   logic [irfg_pkg::LIMIT_W-1:0]              frame_rate_limit;
   logic [irfg_pkg::LIMIT_W-1:0]              exp_cnt;
   logic [irfg_pkg::LIMIT_W-1:0]              frame_cnt;
   logic [31:0]                               ctrl;
   logic [7:0]                                fault_log;
   logic                                      strobe_d;
   logic                                      rise;
   logic                                      fall;
   logic                                      uvlo;
   logic                                      hard_off;
   logic                                      fault_flag_n_en;
   logic                                      frame_done;
   logic                                      start;
   logic                                      exp_expire;
   logic                                      open_load;
   logic                                      short_gnd;
   logic                                      short_supply;
   logic                                      too_frequent;
   logic                                      aw_got;
   logic                                      w_got;
   logic [irfg_pkg::ADDR_W-1:0]               awaddr_q;
   logic [31:0]                               wdata_q;
   logic [3:0]                                wstrb_q;
   logic                                      wr_fire;
   logic [2:0]                                wr_idx;
   logic [31:0]                               wr_merged;
   logic [31:0]                               reg_word [5];

   // Register index of a byte address, REG_NONE when unmapped
   function automatic logic [2:0] reg_index(input logic [irfg_pkg::ADDR_W-1:0] a);
      case (a)
         irfg_pkg::CTRL_OFFSET: reg_index = 3'h0;
         irfg_pkg::EXPOSURE_OFFSET: reg_index = 3'h1;
         irfg_pkg::RATE_OFFSET: reg_index = 3'h2;
         irfg_pkg::STATUS_OFFSET: reg_index = 3'h3;
         irfg_pkg::FAULT_LOG_OFFSET: reg_index = 3'h4;
         default: reg_index = irfg_pkg::REG_NONE;
      endcase
   endfunction

   function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   irfg_sync #(
      .WIDTH($bits(irfg_pkg::irfg_sense_t))
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .async_in(sense),
      .sync_out(sense_s)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         strobe_d <= 1'b0;
      end else begin
         strobe_d <= sense_s.strobe;
      end
   end

   assign rise = sense_s.strobe && !strobe_d;
   assign fall = !sense_s.strobe && strobe_d;
   assign uvlo = !sense_s.main_supply_ok;
   assign fault_flag_n_en = ctrl[irfg_pkg::CTRL_FAULT_FLAG_N_EN_BIT] && sense_s.string_supply_ok && !uvlo;
   assign hard_off = uvlo || filt_hit[irfg_pkg::FILT_THERM] || filt_hit[irfg_pkg::FILT_RES];
   assign frame_done = (frame_cnt == 24'h00_0000);
   assign start = (state != irfg_pkg::ST_ON) && sense_s.strobe && frame_done && !hard_off;
   assign exp_expire = (state == irfg_pkg::ST_ON) && sense_s.strobe && (exp_cnt <= 24'h00_0001);

   assign filt_cond[irfg_pkg::FILT_OPEN] = sense_s.current_low && sense_s.strobe
                                           && (state == irfg_pkg::ST_ON) && fault_flag_n_en;
   // ground short only with drive off
   assign filt_cond[irfg_pkg::FILT_GND] = sense_s.cathode_low && !sense_s.strobe
                                          && !switch_drive && fault_flag_n_en;
   assign filt_cond[irfg_pkg::FILT_SUPPLY] = sense_s.cathode_high && sense_s.strobe
                                             && (state == irfg_pkg::ST_ON) && fault_flag_n_en;
   assign filt_cond[irfg_pkg::FILT_THERM] = sense_s.over_temp;
   assign filt_cond[irfg_pkg::FILT_RES] = sense_s.exposure_resistor_short || sense_s.exposure_resistor_open
                                          || sense_s.rate_resistor_short || sense_s.rate_resistor_open;

   for (genvar g = 0; g < irfg_pkg::FILT_N; g++) begin : g_filt
      irfg_blank u_blank (
         .aclk   (aclk),
         .aresetn(aresetn),
         .cond   (filt_cond[g]),
         .limit  (irfg_pkg::FILT_LIMIT[g]),
         .hit    (filt_hit[g])
      );
   end

   // frame timer armed at reset and during undervoltage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_cnt <= irfg_pkg::LIMIT_W'(FRAME_RATE_CYCLES);
      end else if (uvlo || start) begin
         frame_cnt <= frame_rate_limit;
      end else if (!frame_done) begin
         frame_cnt <= frame_cnt - 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exp_cnt <= 24'h00_0000;
      end else if (start) begin
         exp_cnt <= exposure_limit;
      end else if (state == irfg_pkg::ST_ON && exp_cnt != 24'h00_0000) begin
         exp_cnt <= exp_cnt - 1'b1;
      end
   end

   // held strobe restarts from LIMIT when the frame timer runs out
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= irfg_pkg::ST_IDLE;
      end else begin
         case (state)
            irfg_pkg::ST_IDLE: begin
               if (start) begin
                  state <= irfg_pkg::ST_ON;
               end
            end
            irfg_pkg::ST_ON: begin
               if (uvlo || !sense_s.strobe) begin
                  state <= irfg_pkg::ST_IDLE;
               end else if (exp_expire) begin
                  state <= irfg_pkg::ST_LIMIT;
               end
            end
            irfg_pkg::ST_LIMIT: begin
               if (uvlo || !sense_s.strobe) begin
                  state <= irfg_pkg::ST_IDLE;
               end else if (start) begin
                  state <= irfg_pkg::ST_ON;
               end
            end
            default: begin
               state <= irfg_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // diagnostics other than supply short leave the drive alone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         switch_drive <= 1'b0;
      end else begin
         switch_drive <= (state == irfg_pkg::ST_ON) && sense_s.strobe && !hard_off
                         && !short_supply && !exp_expire;
      end
   end

   // open load latch, set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         open_load <= 1'b0;
      end else if (filt_hit[irfg_pkg::FILT_OPEN]) begin
         open_load <= 1'b1;
      // A fault still standing at expiry clears once the limit state drops it
      end else if (fall || exp_expire || state == irfg_pkg::ST_LIMIT) begin
         open_load <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         short_gnd <= 1'b0;
      end else if (filt_hit[irfg_pkg::FILT_GND]) begin
         short_gnd <= 1'b1;
      end else if (rise) begin
         short_gnd <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         short_supply <= 1'b0;
      end else if (filt_hit[irfg_pkg::FILT_SUPPLY]) begin
         short_supply <= 1'b1;
      end else if (fall || exp_expire || state == irfg_pkg::ST_LIMIT) begin
         short_supply <= 1'b0;
      end
   end

   // strobe too early holds until frame timer ends
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         too_frequent <= 1'b0;
      end else if (sense_s.strobe && state == irfg_pkg::ST_IDLE && !frame_done && !uvlo) begin
         too_frequent <= 1'b1;
      end else if (frame_done) begin
         too_frequent <= 1'b0;
      end
   end

   always_comb begin
      faults.undervoltage = uvlo;
      faults.thermal = filt_hit[irfg_pkg::FILT_THERM];
      faults.resistor = filt_hit[irfg_pkg::FILT_RES];
      faults.too_frequent = too_frequent;
      faults.too_long = (state == irfg_pkg::ST_LIMIT);
      faults.short_supply = short_supply;
      faults.short_gnd = short_gnd;
      faults.open_load = open_load;
   end

   // open-drain flag, low while any fault stands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_flag_n_out <= 1'b0;
         fault_flag_n_oe <= 1'b1;
      end else begin
         fault_flag_n_out <= 1'b0;
         fault_flag_n_oe <= |faults;
      end
   end

   // Register views, unmapped bits read zero
   assign reg_word[0] = ctrl;
   assign reg_word[1] = {8'h00, exposure_limit};
   assign reg_word[2] = {8'h00, frame_rate_limit};
   assign reg_word[3] = {22'h00_0000, switch_drive, sense_s.strobe, faults};
   assign reg_word[4] = {24'h00_0000, fault_log};

   assign wr_fire = aw_got && w_got && !s_axi_bvalid;
   assign wr_idx = reg_index(awaddr_q);
   assign wr_merged = apply_strb((wr_idx < 3'h5) ? reg_word[wr_idx] : 32'h0000_0000, wdata_q, wstrb_q);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= irfg_pkg::CTRL_RESET;
         exposure_limit <= irfg_pkg::LIMIT_W'(EXPOSURE_CYCLES);
         frame_rate_limit <= irfg_pkg::LIMIT_W'(FRAME_RATE_CYCLES);
      end else if (wr_fire) begin
         if (wr_idx == 3'h0) begin
            ctrl <= {31'h0000_0000, wr_merged[irfg_pkg::CTRL_FAULT_FLAG_N_EN_BIT]};
         end
         if (wr_idx == 3'h1) begin
            exposure_limit <= wr_merged[irfg_pkg::LIMIT_W-1:0];
         end
         if (wr_idx == 3'h2) begin
            frame_rate_limit <= wr_merged[irfg_pkg::LIMIT_W-1:0];
         end
      end
   end

   // Sticky record, write one to clear; a fault present keeps its bit set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_log <= 8'h00;
      end else if (wr_fire && wr_idx == 3'h4 && wstrb_q[0]) begin
         fault_log <= (fault_log & ~wdata_q[7:0]) | faults;
      end else begin
         fault_log <= fault_log | faults;
      end
   end

   // Write channels: address and data held until the response is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= irfg_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_idx == irfg_pkg::REG_NONE) ? irfg_pkg::RESP_SLVERR : irfg_pkg::RESP_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Read channel: one read at a time, data one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= irfg_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         if (reg_index(s_axi_araddr) == irfg_pkg::REG_NONE) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= irfg_pkg::RESP_SLVERR;
         end else begin
            s_axi_rdata <= reg_word[reg_index(s_axi_araddr)];
            s_axi_rresp <= irfg_pkg::RESP_OKAY;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** irfg_pkg.sv ***
// Shared constants, register map and carrier types of the IR flash safety gate
package irfg_pkg;

   // Functional clock
   localparam int CLK_MHZ = 125;

   // Pulse limits in microseconds and their clock counts
   localparam int EXPOSURE_LIMIT_US = 6000;
   localparam int FRAME_RATE_LIMIT_US = 8000;
   localparam int EXPOSURE_CYCLES = EXPOSURE_LIMIT_US * CLK_MHZ;
   localparam int FRAME_RATE_CYCLES = FRAME_RATE_LIMIT_US * CLK_MHZ;

   // Blanking and filter times in nanoseconds and their clock counts
   localparam int OPEN_BLANK_NS = 22000;
   localparam int GND_BLANK_NS = 10000;
   localparam int SUPPLY_BLANK_NS = 10000;
   localparam int FILTER_NS = 1000;
   localparam int OPEN_BLANK_CYCLES = OPEN_BLANK_NS * CLK_MHZ / 1000;
   localparam int GND_BLANK_CYCLES = GND_BLANK_NS * CLK_MHZ / 1000;
   localparam int SUPPLY_BLANK_CYCLES = SUPPLY_BLANK_NS * CLK_MHZ / 1000;
   localparam int FILTER_CYCLES = FILTER_NS * CLK_MHZ / 1000;

   // Counter widths
   localparam int LIMIT_W = 24;
   localparam int BLANK_W = 12;

   // Filter channels
   localparam int FILT_OPEN = 0;
   localparam int FILT_GND = 1;
   localparam int FILT_SUPPLY = 2;
   localparam int FILT_THERM = 3;
   localparam int FILT_RES = 4;
   localparam int FILT_N = 5;
   localparam logic [FILT_N-1:0][BLANK_W-1:0] FILT_LIMIT = {
      BLANK_W'(FILTER_CYCLES), BLANK_W'(FILTER_CYCLES), BLANK_W'(SUPPLY_BLANK_CYCLES),
      BLANK_W'(GND_BLANK_CYCLES), BLANK_W'(OPEN_BLANK_CYCLES)};

   // Register map (byte addresses)
   localparam int ADDR_W = 8;
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] EXPOSURE_OFFSET = 8'h04;
   localparam logic [7:0] RATE_OFFSET = 8'h08;
   localparam logic [7:0] STATUS_OFFSET = 8'h0c;
   localparam logic [7:0] FAULT_LOG_OFFSET = 8'h10;
   localparam logic [2:0] REG_NONE = 3'h7;
   localparam int CTRL_FAULT_FLAG_N_EN_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam int STATUS_STROBE_BIT = 8;
   localparam int STATUS_DRIVE_BIT = 9;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Comparator and pin inputs, all asynchronous to aclk
   typedef struct packed {
      logic strobe;
      logic current_low;
      logic cathode_low;
      logic cathode_high;
      logic string_supply_ok;
      logic main_supply_ok;
      logic over_temp;
      logic exposure_resistor_short;
      logic exposure_resistor_open;
      logic rate_resistor_short;
      logic rate_resistor_open;
   } irfg_sense_t;

   // Fault causes, one bit each
   typedef struct packed {
      logic undervoltage;
      logic thermal;
      logic resistor;
      logic too_frequent;
      logic too_long;
      logic short_supply;
      logic short_gnd;
      logic open_load;
   } irfg_fault_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ON,
      ST_LIMIT
   } irfg_state_t;

endpackage

// *** irfg_sync.sv ***
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module irfg_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // Reset value zero reads as supply not ready, which keeps the gate shut
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule
`default_nettype wire

// *** irfg_blank.sv ***
// Persistence filter: a condition must hold for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module irfg_blank (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic                        cond,
   input  wire logic [irfg_pkg::BLANK_W-1:0] limit,
   output logic                             hit
);
   logic [irfg_pkg::BLANK_W-1:0] cnt;

   // Any drop of the condition restarts the blanking
   always_ff @(posedge aclk) begin
      if (!aresetn || !cond) begin
         cnt <= {irfg_pkg::BLANK_W{1'b0}};
      end else if (cnt != limit) begin
         cnt <= cnt + 1'b1;
      end
   end

   assign hit = cond && (cnt == limit);
endmodule
`default_nettype wire

// *** irfg_gate_chk.sv ***
// Port checker of the IR flash safety gate
`timescale 1ns/1ps
`default_nettype none
module irfg_gate_chk #(
   parameter int EXPOSURE_CYCLES   = irfg_pkg::EXPOSURE_CYCLES,
   parameter int FRAME_RATE_CYCLES = irfg_pkg::FRAME_RATE_CYCLES
) (
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic                  s_axi_rvalid,
   input wire irfg_pkg::irfg_sense_t sense,
   input wire logic                  switch_drive,
   input wire logic                  fault_flag_n_oe
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   int   on_cnt;
   int   gap;
   int   hard;
   logic prev;
   // Gap counts cycles between drive rises; hard counts a standing thermal or resistor input
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         on_cnt <= 0;
         gap <= 0;
         hard <= 0;
         prev <= 1'h0;
      end else begin
         on_cnt <= switch_drive ? on_cnt + 1 : 0;
         gap <= (switch_drive && !prev) ? 1 : gap + 1;
         hard <= (sense[4:0] != 5'h0) ? hard + 1 : 0;
         prev <= switch_drive;
      end
   end
   property p_uvlo;
      !sense.main_supply_ok [*4] |=> !switch_drive && fault_flag_n_oe;
   endproperty
   a_uvlo: assert property (p_uvlo) else $error("drive or flag wrong in undervoltage");
   property p_idle_off;
      !sense.strobe [*6] |=> !switch_drive;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("drive without strobe");
   property p_expo;
      switch_drive |-> on_cnt < EXPOSURE_CYCLES;
   endproperty
   a_expo: assert property (p_expo) else $error("drive longer than exposure limit");
   property p_gap;
      switch_drive && !prev |-> gap >= FRAME_RATE_CYCLES;
   endproperty
   a_gap: assert property (p_gap) else $error("drive pulses too close");
   property p_cause;
      $rose(switch_drive) |-> $past(sense.strobe, 3);
   endproperty
   a_cause: assert property (p_cause) else $error("drive rose without strobe");
   property p_hard_off;
      hard >= 135 |-> !switch_drive;
   endproperty
   a_hard_off: assert property (p_hard_off) else $error("drive on during hard fault");
   property p_hard_flag;
      hard >= 135 |-> fault_flag_n_oe;
   endproperty
   a_hard_flag: assert property (p_hard_flag) else $error("flag idle during hard fault");
   property p_rd_ans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
   property p_rd_busy;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_rd_busy: assert property (p_rd_busy) else $error("read taken while busy");
endmodule
bind irfg_gate irfg_gate_chk #(
   .EXPOSURE_CYCLES(EXPOSURE_CYCLES),
   .FRAME_RATE_CYCLES(FRAME_RATE_CYCLES)
) chk_u (
   .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .sense(sense), .switch_drive(switch_drive), .fault_flag_n_oe(fault_flag_n_oe)
);
`default_nettype wire

// *** irfg_sensor_model.sv ***
// Sensor strobe source and pulled-up fault line
`timescale 1ns/1ps
`default_nettype none
module irfg_sensor_model (
   input  wire logic        aclk,
   input  wire logic        go,
   input  wire logic [15:0] len,
   input  wire logic        flag_oe,
   output logic             strobe,
   output logic             flag_n
);
   logic [15:0] cnt = 16'h0;
   always_ff @(posedge aclk) begin
      if (go) begin
         cnt <= len;
      end else if (cnt != 16'h0) begin
         cnt <= cnt - 16'h1;
      end
   end
   assign strobe = (cnt != 16'h0);
   assign flag_n = flag_oe ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Bench: registers, strobe limiting and fault flag
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                  aclk = 1'h0;
   logic                  aresetn = 1'h0;
   logic [7:0]            awaddr = 8'h0;
   logic [7:0]            araddr = 8'h0;
   logic [31:0]           wdata = 32'h0;
   logic                  awvalid = 1'h0;
   logic                  wvalid = 1'h0;
   logic                  arvalid = 1'h0;
   logic                  go = 1'h0;
   logic [15:0]           len = 16'h0;
   irfg_pkg::irfg_sense_t sv = '0;
   logic                  strb, awready, wready, bvalid, arready, rvalid, drive, fl_out, fl_oe, flag_n;
   logic [31:0]           rdata;
   logic [1:0]            bresp, rresp;
   int                    error_cnt = 0;
   int                    checks = 0;
   wire irfg_pkg::irfg_sense_t sense = {strb, sv[9:0]};
   irfg_gate #(.EXPOSURE_CYCLES(40), .FRAME_RATE_CYCLES(100)) dut_u (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(1'h1), .sense(sense), .switch_drive(drive), .fault_flag_n_out(fl_out), .fault_flag_n_oe(fl_oe));
   irfg_sensor_model sm_u (.aclk(aclk), .go(go), .len(len), .flag_oe(fl_oe), .strobe(strb), .flag_n(flag_n));
   initial forever #4 aclk = ~aclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      logic pa, pw;
      pa = 1'h1;
      pw = 1'h1;
      awaddr <= a;
      wdata <= v;
      while (pa | pw) begin
         awvalid <= pa;
         wvalid <= pw;
         @(posedge aclk);
         if (awready) pa = 1'h0;
         if (wready) pw = 1'h0;
      end
      awvalid <= 1'h0;
      wvalid <= 1'h0;
      do @(posedge aclk); while (!bvalid);
      chk(bresp, er);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'h1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge aclk); while (!rvalid);
      chk(rdata, v);
      chk(rresp, er);
   endtask
   task automatic pulse(input logic [15:0] n);
      go <= 1'h1;
      len <= n;
      @(posedge aclk);
      go <= 1'h0;
   endtask
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (6) @(posedge aclk);
      chk(drive, 32'h0);
      chk(flag_n, 32'h0);
      chk(fl_out, 32'h0);
      rd(irfg_pkg::CTRL_OFFSET, irfg_pkg::CTRL_RESET, irfg_pkg::RESP_OKAY);
      wr(irfg_pkg::EXPOSURE_OFFSET, 32'h28, irfg_pkg::RESP_OKAY);
      wr(irfg_pkg::RATE_OFFSET, 32'h64, irfg_pkg::RESP_OKAY);
      rd(irfg_pkg::EXPOSURE_OFFSET, 32'h28, irfg_pkg::RESP_OKAY);
      wr(8'h14, 32'h1, irfg_pkg::RESP_SLVERR);
      rd(8'h14, 32'h0, irfg_pkg::RESP_SLVERR);
      sv.main_supply_ok <= 1'h1;
      sv.string_supply_ok <= 1'h1;
      pulse(16'h14);
      repeat (10) @(posedge aclk);
      chk(drive, 32'h0);
      chk(flag_n, 32'h0);
      repeat (120) @(posedge aclk);
      chk(flag_n, 32'h1);
      pulse(16'h14);
      repeat (8) @(posedge aclk);
      chk(drive, 32'h1);
      chk(flag_n, 32'h1);
      repeat (20) @(posedge aclk);
      chk(drive, 32'h0);
      // Third strobe lands well inside the frame period
      pulse(16'h14);
      repeat (8) @(posedge aclk);
      chk(drive, 32'h0);
      chk(flag_n, 32'h0);
      repeat (100) @(posedge aclk);
      pulse(16'hffff);
      repeat (8) @(posedge aclk);
      chk(drive, 32'h1);
      repeat (45) @(posedge aclk);
      chk(drive, 32'h0);
      chk(flag_n, 32'h0);
      for (int i = 0; i < 150 && !drive; i++) @(posedge aclk);
      chk(drive, 32'h1);
      pulse(16'h1);
      sv.cathode_low <= 1'h1;
      repeat (1200) @(posedge aclk);
      chk(flag_n, 32'h1);
      repeat (80) @(posedge aclk);
      chk(flag_n, 32'h0);
      sv.cathode_low <= 1'h0;
      repeat (10) @(posedge aclk);
      chk(flag_n, 32'h0);
      pulse(16'ha);
      repeat (8) @(posedge aclk);
      chk(drive, 32'h1);
      chk(flag_n, 32'h1);
      repeat (20) @(posedge aclk);
      for (int i = 0; i < 5; i++) begin
         sv[i] <= 1'h1;
         repeat (140) @(posedge aclk);
         pulse(16'h14);
         repeat (8) @(posedge aclk);
         chk(drive, 32'h0);
         chk(flag_n, 32'h0);
         sv[i] <= 1'h0;
         repeat (30) @(posedge aclk);
         chk(flag_n, 32'h1);
      end
      rd(irfg_pkg::FAULT_LOG_OFFSET, 32'hfa, irfg_pkg::RESP_OKAY);
      wr(irfg_pkg::FAULT_LOG_OFFSET, 32'hff, irfg_pkg::RESP_OKAY);
      rd(irfg_pkg::FAULT_LOG_OFFSET, 32'h0, irfg_pkg::RESP_OKAY);
      results;
   end
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      results;
   end
endmodule
`default_nettype wire
